// File: rtl/local_port_defines.svh
`ifndef LOCAL_PORT_DEFINES_SVH
`define LOCAL_PORT_DEFINES_SVH
`define REG_OFFSET_BITS   12
`define IDMA_CODE         4'hF
`define CODE_W            4
`define BURST_MAX_BEATS   3'h4
`define BURST_READ_BEATS  3'h4
`define RD_DEFAULT        32'h00000000
`endif

// File: rtl/local_port_pkg.sv
package local_port_pkg;
	typedef enum logic {STYLE_FALL, STYLE_RISE} style_t;
	typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_RELEASE} mst_t;
	typedef enum logic [1:0] {S_IDLE, S_DATA, S_ACK, S_PARK} slv_t;
endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser: output changes only once stages two and three agree
module pin_sync #(
	parameter int W     = 1,
	parameter logic [W-1:0] INIT = '1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// pins
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;
	wire  [W-1:0] agree = ~(s2_q ^ s3_q);
	genvar i;
	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk) begin
				if (rst)
					out_q[i] <= INIT[i];
				else if (agree[i])
					out_q[i] <= s3_q[i];
			end
		end
	endgenerate
	assign pinOut = out_q;
endmodule // pin_sync

// File: rtl/local_bus_port.sv
`timescale 1ns/1ps
`include "local_port_defines.svh"
module local_bus_port #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	// clock and resets
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          local_reset_in_n,
	input  wire logic          pciReset,
	input  wire logic          softReset,
	output logic               local_reset_out_n_oe,
	output logic               localReset,
	// style and arbitration configuration
	input  wire logic          asyncArb,
	output logic               styleRise,
	// slave side pins
	input  wire logic          address_strobe_n_i,
	input  wire logic          transfer_start_n,
	input  wire logic          pci_window_select_n,
	input  wire logic          image_select,
	input  wire logic          rw_i,
	input  wire logic [3:0]    transaction_code_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] data_i,
	input  wire logic          burst_last_beat_n_i,
	// slave strobes and acks
	output logic               size_ack0_n_o,
	output logic               size_ack1_transfer_ack_n_o,
	output logic               ack_oe,
	output logic               bus_error_n_o,
	output logic               bus_error_n_oe,
	// master side pins
	output logic               address_strobe_n_o,
	output logic               data_strobe_n_o,
	output logic               strobe_oe,
	output logic               rw_o,
	output logic [3:0]         transaction_code_o,
	output logic [AW-1:0]      addr_o,
	output logic [DW-1:0]      data_o,
	output logic               data_oe,
	output logic               addr_oe,
	output logic               burst_last_beat_n_o,
	output logic               burst_last_beat_n_oe,
	input  wire logic          ack_n_i,
	input  wire logic          bus_error_n_i,
	// arbitration
	output logic               bus_request_n,
	input  wire logic          bus_grant_n,
	input  wire logic          bus_busy_n_i,
	output logic               bus_busy_n_o,
	output logic               bus_busy_n_oe,
	// block transfer handshake
	input  wire logic          fifoNeedsService,
	input  wire logic          dma_done_n,
	output logic               dma_request_n,
	// interrupt pin
	input  wire logic          irqEvent,
	input  wire logic          local_irq_n_i,
	output logic               local_irq_n_oe,
	output logic               pciIntOut,
	// user side: slave access results
	input  wire logic [DW-1:0] readData,
	input  wire logic          slaveError,
	output logic               slvValid,
	output logic               slvWrite,
	output logic               slvIsReg,
	output logic               slvImage,
	output logic               slvIsDma,
	output logic [11:0]        slvRegOffset,
	output logic [AW-1:0]      slvAddr,
	output logic [DW-1:0]      slvData,
	output logic [3:0]         slvCode,
	// user side: master requests
	input  wire logic          mstStart,
	input  wire logic          mstWrite,
	input  wire logic [AW-1:0] mstAddr,
	input  wire logic [DW-1:0] mstData,
	input  wire logic [3:0]    imageCode,
	input  wire logic [2:0]    mstBeats,
	output logic               mstBusy,
	output logic               mstDone,
	output logic               mstError
);
	// arbitration inputs from another master cross a clock boundary when async
	logic grantSync;
	logic busySync;
	pin_sync #(.W(2), .INIT(2'h3)) u_arb_sync (
		.mclk   (mclk),
		.rst    (rst),
		.pinIn  ({bus_grant_n, bus_busy_n_i}),
		.pinOut ({grantSync, busySync})
	);
	wire grantN = asyncArb ? grantSync : bus_grant_n;
	wire busyN  = asyncArb ? busySync : bus_busy_n_i;

	// negative-edge captures for the falling-edge style
	logic fallAs_q;
	logic fallDone_q;
	always_ff @(negedge mclk) begin
		fallAs_q   <= address_strobe_n_i;
		fallDone_q <= dma_done_n;
	end

	// local reset: port logic only, pci configuration lives elsewhere
	logic lrst;
	assign lrst = rst | ~local_reset_in_n;
	assign localReset = lrst;
	assign local_reset_out_n_oe = pciReset | softReset;

	// style strap caught after reset release
	logic style_q;
	logic strapped_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			strapped_q <= 1'b0;
			style_q    <= 1'b0;
		end else if (!strapped_q) begin
			strapped_q <= 1'b1;
			style_q    <= burst_last_beat_n_i;
		end
	end
	assign styleRise = style_q;

	// interrupt pin
	assign local_irq_n_oe = irqEvent;
	assign pciIntOut = ~local_irq_n_i & ~irqEvent;

	// block transfer request, held off once done seen
	logic dmaReq_q;
	logic doneSeen_q;
	wire  doneNow = style_q ? ~dma_done_n : ~fallDone_q;
	always_ff @(posedge mclk) begin
		if (lrst)
			doneSeen_q <= 1'b0;
		else if (doneNow)
			doneSeen_q <= 1'b1;
		else if (!fifoNeedsService)
			doneSeen_q <= 1'b0;
	end
	always_ff @(negedge mclk) begin
		dmaReq_q <= fifoNeedsService & ~doneSeen_q & ~doneNow & ~lrst;
	end
	assign dma_request_n = ~dmaReq_q;

	// slave: start seen on the style's strobe
	function automatic logic [11:0] regOffset(input logic [AW-1:0] a);
		return a[`REG_OFFSET_BITS-1:0];
	endfunction
	local_port_pkg::slv_t sst_q;
	logic [1:0] beats_q;
	wire  startFall = ~style_q & ~fallAs_q & (sst_q == local_port_pkg::S_IDLE);
	wire  startRise = style_q & ~transfer_start_n & (sst_q == local_port_pkg::S_IDLE);
	wire  slvStart  = (startFall | startRise) & ~pci_window_select_n;
	wire  lastBeat  = ~style_q | ~burst_last_beat_n_i | (beats_q == 2'h3);
	always_ff @(posedge mclk) begin
		if (lrst) begin
			sst_q   <= local_port_pkg::S_IDLE;
			beats_q <= 2'h0;
		end else begin
			unique case (sst_q)
				local_port_pkg::S_IDLE: begin
					beats_q <= 2'h0;
					if (slvStart)
						sst_q <= local_port_pkg::S_DATA;
				end
				local_port_pkg::S_DATA: sst_q <= local_port_pkg::S_ACK;
				local_port_pkg::S_ACK: begin
					beats_q <= beats_q + 2'h1;
					if (style_q ? lastBeat : fallAs_q)
						sst_q <= local_port_pkg::S_PARK;
				end
				local_port_pkg::S_PARK: sst_q <= local_port_pkg::S_IDLE;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (lrst) begin
			slvValid     <= 1'b0;
			slvWrite     <= 1'b0;
			slvIsReg     <= 1'b0;
			slvImage     <= 1'b0;
			slvIsDma     <= 1'b0;
			slvRegOffset <= 12'h000;
			slvAddr      <= '0;
			slvData      <= '0;
			slvCode      <= 4'h0;
		end else begin
			slvValid <= sst_q == local_port_pkg::S_DATA;
			if (slvStart) begin
				slvAddr      <= addr_i;
				slvRegOffset <= regOffset(addr_i);
				slvImage     <= image_select;
				slvWrite     <= ~rw_i;
				slvIsReg     <= 1'b0;
			end
			if (sst_q == local_port_pkg::S_DATA) begin
				slvData  <= data_i;
				slvCode  <= transaction_code_i;
				slvIsDma <= transaction_code_i == `IDMA_CODE;
			end
		end
	end
	// acknowledge: both size acks low, park high for one and a half clocks, then float
	logic ackPark_q;
	always_ff @(negedge mclk) begin
		ackPark_q <= sst_q == local_port_pkg::S_PARK;
	end
	wire ackActive = sst_q == local_port_pkg::S_ACK;
	assign size_ack0_n_o              = ~(ackActive & ~slaveError);
	assign size_ack1_transfer_ack_n_o = ~(ackActive & ~slaveError);
	assign ack_oe = ackActive | (sst_q == local_port_pkg::S_PARK) | ackPark_q;
	assign bus_error_n_o  = ~(ackActive & slaveError);
	assign bus_error_n_oe = ackActive | (sst_q == local_port_pkg::S_PARK);

	// master with three-wire arbitration
	local_port_pkg::mst_t mst_q;
	logic          mstOe_q;
	logic [DW-1:0] mData_q;
	logic [2:0]    mBeat_q;
	logic          grantSeen_q;
	logic          dsFall_q;
	assign data_o = mstOe_q ? mData_q : readData;
	always_ff @(posedge mclk) begin
		if (lrst) begin
			mst_q       <= local_port_pkg::M_IDLE;
			mstOe_q     <= 1'b0;
			mData_q     <= '0;
			mBeat_q     <= 3'h0;
			grantSeen_q <= 1'b0;
			mstDone     <= 1'b0;
			mstError    <= 1'b0;
			addr_o      <= '0;
			rw_o        <= 1'b1;
			transaction_code_o <= 4'h0;
		end else begin
			mstDone <= 1'b0;
			unique case (mst_q)
				local_port_pkg::M_IDLE: begin
					grantSeen_q <= 1'b0;
					if (mstStart) begin
						mst_q   <= local_port_pkg::M_REQ;
						addr_o  <= mstAddr;
						rw_o    <= ~mstWrite;
						transaction_code_o <= imageCode;
						mData_q <= mstData;
						mBeat_q <= mstWrite ? mstBeats : `BURST_READ_BEATS;
					end
				end
				local_port_pkg::M_REQ: begin
					if (!grantN && busyN)
						grantSeen_q <= 1'b1;
					if (grantSeen_q) begin
						mst_q   <= local_port_pkg::M_ADDR;
						mstOe_q <= 1'b1;
					end
				end
				local_port_pkg::M_ADDR: mst_q <= local_port_pkg::M_DATA;
				local_port_pkg::M_DATA: begin
					if (!bus_error_n_i) begin
						mstError <= 1'b1;
						mst_q    <= local_port_pkg::M_RELEASE;
					end else if (!ack_n_i) begin
						mBeat_q <= mBeat_q - 3'h1;
						if (mBeat_q <= 3'h1 || !style_q)
							mst_q <= local_port_pkg::M_RELEASE;
					end
				end
				local_port_pkg::M_RELEASE: begin
					mstOe_q <= 1'b0;
					mstDone <= 1'b1;
					mst_q   <= local_port_pkg::M_IDLE;
				end
			endcase
		end
	end
	// write data strobe trails the address strobe by half a clock
	always_ff @(negedge mclk) begin
		dsFall_q <= (mst_q == local_port_pkg::M_DATA);
	end
	wire asOn = (mst_q == local_port_pkg::M_DATA);
	assign address_strobe_n_o = ~asOn;
	assign data_strobe_n_o    = rw_o ? ~asOn : ~(asOn & dsFall_q);
	assign strobe_oe  = mstOe_q; // strobes negated in release before float
	assign addr_oe    = mstOe_q;
	assign data_oe    = (mstOe_q & ~rw_o) | (ackActive & ~slvWrite);
	assign burst_last_beat_n_o  = ~(asOn & ~rw_o & style_q & (mBeat_q == 3'h2));
	assign burst_last_beat_n_oe = mstOe_q & style_q;
	assign bus_request_n = ~(mst_q == local_port_pkg::M_REQ);
	assign bus_busy_n_o  = ~(asOn | (mst_q == local_port_pkg::M_ADDR));
	assign bus_busy_n_oe = mstOe_q;
	assign mstBusy = mst_q != local_port_pkg::M_IDLE;

	// checks
	both_acks_a: assert property (@(posedge mclk) disable iff (lrst)
		size_ack0_n_o == size_ack1_transfer_ack_n_o) else $error("size acks differ");
	park_float_a: assert property (@(posedge mclk) disable iff (lrst)
		sst_q == local_port_pkg::S_PARK |=> !ackActive) else $error("ack not released");
	busy_grant_a: assert property (@(posedge mclk) disable iff (lrst)
		$rose(grantSeen_q) |=> !bus_busy_n_o) else $error("busy late after grant");
	reset_out_a: assert property (@(posedge mclk)
		pciReset |-> local_reset_out_n_oe) else $error("reset out missing");
	done_stop_a: assert property (@(posedge mclk) disable iff (lrst)
		doneSeen_q |=> ##1 dma_request_n) else $error("request after done");
	code_drive_a: assert property (@(posedge mclk) disable iff (lrst)
		asOn |-> addr_oe) else $error("code not driven");
	read_ds_a: assert property (@(posedge mclk) disable iff (lrst)
		rw_o && mstOe_q |-> data_strobe_n_o == address_strobe_n_o) else $error("read strobe skew");
	irq_pin_a: assert property (@(posedge mclk)
		irqEvent |-> local_irq_n_oe) else $error("irq not driven");
endmodule // local_bus_port

// File: sim/local_master_model.sv
`timescale 1ns/1ps
// far-side arbiter and slave: grants the bus and acknowledges the port's own cycles
module local_master_model (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// arbitration
	input  wire logic bus_request_n,
	output logic      bus_grant_n,
	// port as master
	input  wire logic strobe_oe,
	input  wire logic address_strobe_n_o,
	input  wire logic slow,
	output logic      ack_n_i
);
	logic [2:0] waitQ;
	wire        strobeOn = strobe_oe && !address_strobe_n_o;
	wire        ackNow   = strobeOn && (waitQ >= (slow ? 3'h3 : 3'h0));
	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_grant_n <= 1'b1;
			waitQ       <= 3'h0;
			ack_n_i     <= 1'b1;
		end else begin
			bus_grant_n <= bus_request_n;
			waitQ       <= strobeOn ? waitQ + 3'h1 : 3'h0;
			// held until the strobe goes; the line is pulled up once released
			ack_n_i     <= !ackNow;
		end
	end
endmodule // local_master_model

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
	logic mclk = 0, rst = 1, local_reset_in_n = 1, pciReset = 0, softReset = 0, asyncArb = 0;
	logic address_strobe_n_i = 1, transfer_start_n = 1, pci_window_select_n = 1, image_select = 0, rw_i = 1;
	logic [3:0] transaction_code_i = 4'h0, imageCode = 4'h0;
	logic [31:0] addr_i = '0, data_i = '0, readData = '0, mstAddr = '0, mstData = '0;
	logic burst_last_beat_n_i = 0, bus_error_n_i = 1, fifoNeedsService = 0, dma_done_n = 1, irqEvent = 0;
	logic slaveError = 0, mstStart = 0, mstWrite = 0, slow = 0, extIrqLow = 0;
	logic [2:0] mstBeats = 3'h1;
	logic local_reset_out_n_oe, localReset, styleRise, size_ack0_n_o, size_ack1_transfer_ack_n_o, ack_oe;
	logic bus_error_n_o, bus_error_n_oe, address_strobe_n_o, data_strobe_n_o, strobe_oe, rw_o, data_oe;
	logic addr_oe, burst_last_beat_n_o, burst_last_beat_n_oe, ack_n_i, bus_request_n, bus_grant_n;
	logic bus_busy_n_o, bus_busy_n_oe, dma_request_n, local_irq_n_oe, pciIntOut, slvValid, slvWrite;
	logic slvIsReg, slvImage, slvIsDma, mstBusy, mstDone, mstError;
	logic [3:0] transaction_code_o, slvCode;
	logic [31:0] addr_o, data_o, slvAddr, slvData;
	logic [11:0] slvRegOffset;
	int err_total = 0, check_count = 0, cycles = 0;
	// pulled-up wires resolved from every party's enable
	wire bus_busy_n_i  = bus_busy_n_oe ? bus_busy_n_o : 1'b1;
	wire local_irq_n_i = !(local_irq_n_oe || extIrqLow);

	local_bus_port dut (.mclk, .rst, .local_reset_in_n, .pciReset, .softReset, .local_reset_out_n_oe,
		.localReset, .asyncArb, .styleRise, .address_strobe_n_i, .transfer_start_n, .pci_window_select_n,
		.image_select, .rw_i, .transaction_code_i, .addr_i, .data_i, .burst_last_beat_n_i, .size_ack0_n_o,
		.size_ack1_transfer_ack_n_o, .ack_oe, .bus_error_n_o, .bus_error_n_oe, .address_strobe_n_o,
		.data_strobe_n_o, .strobe_oe, .rw_o, .transaction_code_o, .addr_o, .data_o, .data_oe, .addr_oe,
		.burst_last_beat_n_o, .burst_last_beat_n_oe, .ack_n_i, .bus_error_n_i, .bus_request_n, .bus_grant_n,
		.bus_busy_n_i, .bus_busy_n_o, .bus_busy_n_oe, .fifoNeedsService, .dma_done_n, .dma_request_n,
		.irqEvent, .local_irq_n_i, .local_irq_n_oe, .pciIntOut, .readData, .slaveError, .slvValid, .slvWrite,
		.slvIsReg, .slvImage, .slvIsDma, .slvRegOffset, .slvAddr, .slvData, .slvCode, .mstStart, .mstWrite,
		.mstAddr, .mstData, .imageCode, .mstBeats, .mstBusy, .mstDone, .mstError);
	local_master_model partner (.mclk, .rst, .bus_request_n, .bus_grant_n, .strobe_oe, .address_strobe_n_o,
		.slow, .ack_n_i);

	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (err_total == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic step();
		@(posedge mclk);
		#1;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, seen);
			err_total++;
		end
	endtask
	// one slave cycle from the far-side master, falling-edge style
	task automatic slv(input logic win, input logic wr, input logic [31:0] a, input logic [3:0] code,
		output logic got);
		int n;
		address_strobe_n_i = 0;
		pci_window_select_n = win;
		rw_i = !wr;
		addr_i = a;
		data_i = ~a;
		transaction_code_i = code;
		image_select = 1;
		got = 0;
		for (n = 0; n < 8 && !got; n++) begin
			step();
			got = (slvValid === 1'b1);
		end
		for (n = 0; n < 8 && got && size_ack0_n_o !== 1'b0; n++) step();
		if (got) chk("sizeAcks", {1'b0, size_ack0_n_o}, {1'b0, size_ack1_transfer_ack_n_o});
		address_strobe_n_i = 1;
		pci_window_select_n = 1;
		repeat (4) step();
		chk("ackFloat", 0, ack_oe);
	endtask
	// one master cycle of the port, answered by the partner
	task automatic mst(input logic wr, input logic [31:0] a, input logic [3:0] code, input logic slw);
		logic seen, reqSeen;
		logic [31:0] sa, sd;
		logic [3:0] sc;
		logic srw;
		int n;
		seen = 0;
		reqSeen = 0;
		slow = slw;
		{mstStart, mstWrite, mstAddr, mstData, imageCode} = {1'b1, wr, a, ~a, code};
		step();
		mstStart = 0;
		for (n = 0; n < 60 && mstDone !== 1'b1; n++) begin
			step();
			reqSeen |= (bus_request_n === 1'b0);
			if (!seen && strobe_oe && !address_strobe_n_o) begin
				{seen, sa, sd, sc, srw} = {1'b1, addr_o, data_o, transaction_code_o, rw_o};
				if (!wr) chk("readStrobes", 0, data_strobe_n_o);
			end
		end
		chk("mstDone", 1, mstDone);
		chk("busRequest", 1, reqSeen);
		chk("mstAddr", a, sa);
		chk("mstCode", code, sc);
		chk("mstDir", !wr, srw);
		if (wr) chk("mstData", ~a, sd);
	endtask

	initial begin
		logic got;
		repeat (12) @(posedge mclk);
		#1 rst = 0;
		repeat (3) step();
		chk("styleRise", 0, styleRise);
		for (int i = 0; i < 4; i++) begin
			{pciReset, softReset} = 2'(i);
			#1 chk("resetOut", i != 0, local_reset_out_n_oe);
		end
		{pciReset, softReset} = 2'b00;
		local_reset_in_n = 0;
		#1 chk("localReset", 1, localReset);
		local_reset_in_n = 1;
		irqEvent = 1;
		repeat (4) step();
		chk("irqDrive", 1, local_irq_n_oe);
		irqEvent = 0;
		extIrqLow = 1;
		repeat (6) step();
		chk("irqToPci", 1, pciIntOut);
		extIrqLow = 0;
		repeat (4) step();
		slv(0, 1, 32'h1234_5ABC, 4'hF, got);
		chk("slvWrite", 1, {got, slvWrite} == 2'b11);
		chk("slvData", 32'hEDCB_A543, slvData);
		chk("slvCode", 4'hF, slvCode);
		chk("slvAddr", 32'h1234_5ABC, slvAddr);
		chk("slvOffset", 12'hABC, slvRegOffset);
		chk("slvImage", 1, slvImage);
		slv(0, 0, 32'h0000_0FF0, 4'h5, got);
		chk("slvRead", 1, {got, slvWrite, slvCode} == 6'h25);
		slv(1, 1, 32'h0000_0004, 4'h1, got);
		chk("windowOff", 0, got);
		fifoNeedsService = 1;
		repeat (6) step();
		chk("dmaRequest", 0, dma_request_n);
		dma_done_n = 0;
		repeat (3) step();
		repeat (8) begin
			step();
			chk("dmaStopped", 1, dma_request_n);
		end
		fifoNeedsService = 0;
		dma_done_n = 1;
		mst(1, 32'h8000_0010, 4'hA, 0);
		mst(0, 32'h4000_0020, 4'h3, 1);
		complete_run();
	end
endmodule // tb
